// file: include/fbc_params.svh
// Purpose: Constants for the host-side parallel NOR flash command controller.
// Assumes: 40 MHz clock; flash run in word mode.
// Notes: Functional notes below list the behaviour this controller keeps.
//
// Functional notes
// R01 - Query signature at 40h-42h reads PRI.
// R02 - Major and minor version read ASCII one.
// R03 - Word 45h: unlock required, revision zero.
// R04 - Word 46h: erase suspend permits read, write.
// R05 - One sector per group; temporary unprotect supported.
// R06 - Word 4Ah gives uniform bank sector count.
// R07 - Burst and page mode words read zero.
// R08 - Acceleration supply limits 85h and 95h.
// R09 - Word 4Fh gives boot arrangement code.
// R10 - Only defined sequences; reset restores array reads.
// R11 - Address held at WE fall, data at rise.
// R12 - Power-up and completion leave read-array mode.
// R13 - Erase suspend allows reads of other sectors.
// R14 - Host writes reset after error or autoselect.
// R15 - Reset command ignores address, restores read mode.
// R16 - Reset mid-sequence aborts; ignored once running.
// R17 - Reset during suspended program returns suspend-read.
// R18 - Autoselect: two unlocks, bank command, not busy.
// R19 - Autoselect offset 00 manufacturer, 01 device.
// R20 - Autoselect sector word 02 gives protection.
// R21 - Autoselect serves reads until reset.
// R22 - Secure entry three writes, exit four, pin reset.
// R23 - Byte mode query data on low lane.
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH
`define FBC_CLK_NS      25
`define FBC_T_ACC_NS    70
`define FBC_T_WP_NS     35
`define FBC_T_RP_NS     500
`define FBC_CYC_UP(ns)  (((ns) + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_RG_CTRL     3'h0
`define FBC_RG_ADDR     3'h1
`define FBC_RG_WDATA    3'h2
`define FBC_RG_STATUS   3'h3
`define FBC_RG_FDATA    3'h4
`define FBC_UNLOCK1_A   12'h555
`define FBC_UNLOCK2_A   12'h2aa
`define FBC_QUERY_A     12'h055
`define FBC_UNLOCK1_D   8'haa
`define FBC_UNLOCK2_D   8'h55
`define FBC_RESET_D     8'hf0
`define FBC_AUTO_D      8'h90
`define FBC_QUERY_D     8'h98
`define FBC_SEC_D       8'h88
`define FBC_EXIT_D      8'h00
`endif

// file: include/fbc_pkg.sv
// Purpose: Types shared by the flash command controller.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Command codes are written by software into the control register.
package fbc_pkg;
  typedef enum logic [3:0] {
    FBC_CMD_WRITE  = 4'h0,
    FBC_CMD_READ   = 4'h1,
    FBC_CMD_RESET  = 4'h2,
    FBC_CMD_AUTO   = 4'h3,
    FBC_CMD_QUERY  = 4'h4,
    FBC_CMD_SECIN  = 4'h5,
    FBC_CMD_SECOUT = 4'h6,
    FBC_CMD_HWRST  = 4'h7
  } fbc_cmd_t;
  typedef enum logic [1:0] {
    FBC_MODE_ARRAY = 2'h0,
    FBC_MODE_AUTO  = 2'h1,
    FBC_MODE_QUERY = 2'h2,
    FBC_MODE_SEC   = 2'h3
  } fbc_mode_t;
  typedef enum logic [5:0] {
    FBC_ST_IDLE   = 6'h01,
    FBC_ST_SETUP  = 6'h02,
    FBC_ST_WPULSE = 6'h04,
    FBC_ST_WHOLD  = 6'h08,
    FBC_ST_READ   = 6'h10,
    FBC_ST_HWRST  = 6'h20
  } fbc_state_t;
endpackage : fbc_pkg

// file: src/fbc_host.sv
// Purpose: Host controller that drives a dual-bank NOR flash through its pins.
// Assumes: Flash in word mode; pins sampled synchronously to clk.
// Notes: Software starts one command at a time and polls the busy bit.
`timescale 1ns/1ps
`default_nettype none
`include "fbc_params.svh"
module fbc_host #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              reset,
  // Software register port.
  input  wire logic [2:0]        sw_addr,
  input  wire logic [31:0]       sw_wdata,
  input  wire logic              sw_wr,
  input  wire logic              sw_rd,
  output var  logic [31:0]       sw_rdata,
  // Flash pins.
  output var  logic [ADDR_W-1:0] fl_addr,
  input  wire logic [DATA_W-1:0] fl_dq_in,
  output var  logic [DATA_W-1:0] fl_dq_out,
  output var  logic              fl_dq_oe_n,
  output var  logic              fl_ce_n,
  output var  logic              fl_we_n,
  output var  logic              fl_oe_n,
  output var  logic              fl_reset_n,
  input  wire logic              fl_ready
);
  localparam int T_ACC = `FBC_CYC_UP(`FBC_T_ACC_NS);
  localparam int T_WP  = `FBC_CYC_UP(`FBC_T_WP_NS);
  localparam int T_RP  = `FBC_CYC_UP(`FBC_T_RP_NS);

  initial begin
    if (ADDR_W < 12 || ADDR_W > 31 || DATA_W < 8 || DATA_W > 32)
      $error("fbc_host: unsupported ADDR_W or DATA_W");
  end

  // Number of bus writes each command issues.
  function automatic logic [2:0] seq_len(input fbc_pkg::fbc_cmd_t c);
    case (c)
      fbc_pkg::FBC_CMD_WRITE:  seq_len = 3'h1;
      fbc_pkg::FBC_CMD_RESET:  seq_len = 3'h1;
      fbc_pkg::FBC_CMD_AUTO:   seq_len = 3'h3;
      fbc_pkg::FBC_CMD_QUERY:  seq_len = 3'h1;
      fbc_pkg::FBC_CMD_SECIN:  seq_len = 3'h3;
      fbc_pkg::FBC_CMD_SECOUT: seq_len = 3'h4;
      default:                 seq_len = 3'h0;
    endcase
  endfunction : seq_len

  // Address and data of one write cycle of a command sequence.
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input fbc_pkg::fbc_cmd_t c,
      input logic [2:0] s, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [ADDR_W-1:0] wa;
    logic [7:0]        wd;
    wa = ADDR_W'(`FBC_UNLOCK1_A);
    wd = `FBC_UNLOCK1_D;
    if (s == 3'h1) begin
      wa = ADDR_W'(`FBC_UNLOCK2_A);
      wd = `FBC_UNLOCK2_D;
    end
    case (c)
      fbc_pkg::FBC_CMD_WRITE: seq_word = {a, d};
      fbc_pkg::FBC_CMD_RESET: seq_word = {a, DATA_W'(`FBC_RESET_D)};  // [R15]
      fbc_pkg::FBC_CMD_QUERY: seq_word = {ADDR_W'(`FBC_QUERY_A), DATA_W'(`FBC_QUERY_D)};
      fbc_pkg::FBC_CMD_AUTO: begin
        // The third write carries the bank bits of the software address. [R18]
        if (s == 3'h2) begin
          wa = (a & ~ADDR_W'(12'hfff)) | ADDR_W'(`FBC_UNLOCK1_A);
          wd = `FBC_AUTO_D;
        end
        seq_word = {wa, DATA_W'(wd)};
      end
      fbc_pkg::FBC_CMD_SECIN: begin
        if (s == 3'h2) wd = `FBC_SEC_D;  // [R22]
        seq_word = {wa, DATA_W'(wd)};
      end
      fbc_pkg::FBC_CMD_SECOUT: begin
        if (s == 3'h2) wd = `FBC_AUTO_D;
        if (s == 3'h3) wd = `FBC_EXIT_D;  // [R22]
        seq_word = {wa, DATA_W'(wd)};
      end
      default: seq_word = {a, d};
    endcase
  endfunction : seq_word

  fbc_pkg::fbc_state_t state, next_state;
  fbc_pkg::fbc_cmd_t   cmd, next_cmd;
  fbc_pkg::fbc_mode_t  mode, next_mode;
  logic [2:0]          step, next_step;
  logic [7:0]          cnt, next_cnt;
  logic [ADDR_W-1:0]   addr_reg, next_addr_reg;
  logic [DATA_W-1:0]   wdata, next_wdata, fdata, next_fdata;
  logic                refused, next_refused;
  logic [31:0]         next_sw_rdata;
  logic [ADDR_W-1:0]   next_fl_addr;
  logic [DATA_W-1:0]   next_fl_dq_out;
  logic                next_fl_dq_oe_n, next_fl_ce_n, next_fl_we_n, next_fl_oe_n;
  logic                next_fl_reset_n;
  logic                start;
  fbc_pkg::fbc_cmd_t   wcmd;

  assign wcmd  = fbc_pkg::fbc_cmd_t'(sw_wdata[3:0]);
  assign start = sw_wr && sw_addr == `FBC_RG_CTRL && state == fbc_pkg::FBC_ST_IDLE;

  always_comb begin
    next_state      = state;
    next_cmd        = cmd;
    next_mode       = mode;
    next_step       = step;
    next_cnt        = cnt;
    next_addr_reg   = addr_reg;
    next_wdata      = wdata;
    next_fdata      = fdata;
    next_refused    = refused;
    next_sw_rdata   = 32'h0;
    next_fl_addr    = fl_addr;
    next_fl_dq_out  = fl_dq_out;
    next_fl_dq_oe_n = fl_dq_oe_n;
    next_fl_ce_n    = fl_ce_n;
    next_fl_we_n    = fl_we_n;
    next_fl_oe_n    = fl_oe_n;
    next_fl_reset_n = fl_reset_n;
    if (sw_wr && sw_addr == `FBC_RG_ADDR) next_addr_reg = sw_wdata[ADDR_W-1:0];
    if (sw_wr && sw_addr == `FBC_RG_WDATA) next_wdata = sw_wdata[DATA_W-1:0];
    if (sw_rd) begin
      case (sw_addr)
        `FBC_RG_ADDR:   next_sw_rdata = 32'(addr_reg);
        `FBC_RG_WDATA:  next_sw_rdata = 32'(wdata);
        `FBC_RG_STATUS: next_sw_rdata = {27'h0, fl_ready, mode, refused,
                                         state != fbc_pkg::FBC_ST_IDLE};
        `FBC_RG_FDATA:  next_sw_rdata = 32'(fdata);
        default:        next_sw_rdata = 32'h0;
      endcase
    end
    case (state)
      fbc_pkg::FBC_ST_IDLE: begin
        if (start) begin
          next_cmd     = wcmd;
          next_step    = 3'h0;
          next_refused = 1'b0;
          if (wcmd == fbc_pkg::FBC_CMD_AUTO && !fl_ready) begin
            // Autoselect is not offered while a bank is programming or erasing. [R18]
            next_refused = 1'b1;
          end else if (wcmd == fbc_pkg::FBC_CMD_HWRST) begin
            next_fl_reset_n = 1'b0;  // [R22]
            next_cnt        = 8'(T_RP - 1);
            next_state      = fbc_pkg::FBC_ST_HWRST;
          end else if (wcmd == fbc_pkg::FBC_CMD_READ) begin
            next_fl_addr = addr_reg;
            next_fl_ce_n = 1'b0;
            next_fl_oe_n = 1'b0;
            next_cnt     = 8'(T_ACC - 1);
            next_state   = fbc_pkg::FBC_ST_READ;
          end else if (seq_len(wcmd) != 3'h0) begin
            // Address and data settle one cycle before write-enable falls. [R11]
            {next_fl_addr, next_fl_dq_out} = seq_word(wcmd, 3'h0, addr_reg, wdata);
            next_fl_dq_oe_n = 1'b0;
            next_fl_ce_n    = 1'b0;
            next_state      = fbc_pkg::FBC_ST_SETUP;
          end else begin
            next_refused = 1'b1;  // [R10]
          end
        end
      end
      fbc_pkg::FBC_ST_SETUP: begin
        next_fl_we_n = 1'b0;
        next_cnt     = 8'(T_WP - 1);
        next_state   = fbc_pkg::FBC_ST_WPULSE;
      end
      fbc_pkg::FBC_ST_WPULSE: begin
        if (cnt != 8'h0) begin
          next_cnt = cnt - 8'h1;
        end else begin
          // Data stay driven past the rising edge so the flash latches them. [R11]
          next_fl_we_n = 1'b1;
          next_state   = fbc_pkg::FBC_ST_WHOLD;
        end
      end
      fbc_pkg::FBC_ST_WHOLD: begin
        if (step + 3'h1 < seq_len(cmd)) begin
          next_step = step + 3'h1;
          {next_fl_addr, next_fl_dq_out} = seq_word(cmd, step + 3'h1, addr_reg, wdata);
          next_state = fbc_pkg::FBC_ST_SETUP;
        end else begin
          next_fl_dq_oe_n = 1'b1;
          next_fl_ce_n    = 1'b1;
          next_state      = fbc_pkg::FBC_ST_IDLE;
          case (cmd)
            fbc_pkg::FBC_CMD_AUTO:   next_mode = fbc_pkg::FBC_MODE_AUTO;  // [R21]
            fbc_pkg::FBC_CMD_QUERY:  next_mode = fbc_pkg::FBC_MODE_QUERY;
            fbc_pkg::FBC_CMD_SECIN:  next_mode = fbc_pkg::FBC_MODE_SEC;
            fbc_pkg::FBC_CMD_SECOUT: next_mode = fbc_pkg::FBC_MODE_ARRAY;
            fbc_pkg::FBC_CMD_RESET: begin
              // Reset leaves autoselect or query; the secure region needs its exit. [R14]
              if (mode != fbc_pkg::FBC_MODE_SEC) next_mode = fbc_pkg::FBC_MODE_ARRAY;
            end
            default: next_mode = mode;
          endcase
        end
      end
      fbc_pkg::FBC_ST_READ: begin
        if (cnt != 8'h0) begin
          next_cnt = cnt - 8'h1;
        end else begin
          next_fdata   = fl_dq_in;
          next_fl_ce_n = 1'b1;
          next_fl_oe_n = 1'b1;
          next_state   = fbc_pkg::FBC_ST_IDLE;
        end
      end
      fbc_pkg::FBC_ST_HWRST: begin
        if (cnt != 8'h0) begin
          next_cnt = cnt - 8'h1;
        end else begin
          next_fl_reset_n = 1'b1;
          next_mode       = fbc_pkg::FBC_MODE_ARRAY;  // [R22]
          next_state      = fbc_pkg::FBC_ST_IDLE;
        end
      end
      default: next_state = fbc_pkg::FBC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state      <= fbc_pkg::FBC_ST_IDLE;
      cmd        <= fbc_pkg::FBC_CMD_WRITE;
      mode       <= fbc_pkg::FBC_MODE_ARRAY;  // [R12]
      step       <= 3'h0;
      cnt        <= 8'h0;
      addr_reg   <= '0;
      wdata      <= '0;
      fdata      <= '0;
      refused    <= 1'b0;
      sw_rdata   <= 32'h0;
      fl_addr    <= '0;
      fl_dq_out  <= '0;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n    <= 1'b1;
      fl_we_n    <= 1'b1;
      fl_oe_n    <= 1'b1;
      fl_reset_n <= 1'b1;
    end else begin
      state      <= next_state;
      cmd        <= next_cmd;
      mode       <= next_mode;
      step       <= next_step;
      cnt        <= next_cnt;
      addr_reg   <= next_addr_reg;
      wdata      <= next_wdata;
      fdata      <= next_fdata;
      refused    <= next_refused;
      sw_rdata   <= next_sw_rdata;
      fl_addr    <= next_fl_addr;
      fl_dq_out  <= next_fl_dq_out;
      fl_dq_oe_n <= next_fl_dq_oe_n;
      fl_ce_n    <= next_fl_ce_n;
      fl_we_n    <= next_fl_we_n;
      fl_oe_n    <= next_fl_oe_n;
      fl_reset_n <= next_fl_reset_n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_we_addr_hold: assert property (!fl_we_n |=> $stable(fl_addr) || fl_we_n)  // [R11]
    else $error("address moved during write pulse");
  a_we_data_hold: assert property ($rose(fl_we_n) |-> !fl_dq_oe_n && $stable(fl_dq_out))  // [R11]
    else $error("data not held at write-enable rise");
  a_we_setup: assert property ($fell(fl_we_n) |-> !$past(fl_ce_n) && !$past(fl_dq_oe_n))  // [R11]
    else $error("write-enable fell without setup");
  a_we_oe_excl: assert property (!(fl_oe_n == 1'b0 && fl_dq_oe_n == 1'b0))  // [R10]
    else $error("bus contention between read and drive");
  a_auto_refuse: assert property (start && wcmd == fbc_pkg::FBC_CMD_AUTO && !fl_ready  // [R18]
    |=> refused && state == fbc_pkg::FBC_ST_IDLE)
    else $error("autoselect issued while busy");
  a_reset_data: assert property (cmd == fbc_pkg::FBC_CMD_RESET && $fell(fl_we_n)  // [R15]
    |-> fl_dq_out == DATA_W'(`FBC_RESET_D))
    else $error("reset command carries wrong data");
  a_hwrst_pulse: assert property (start && wcmd == fbc_pkg::FBC_CMD_HWRST  // [R22]
    |=> !fl_reset_n [*8])
    else $error("hardware reset pulse too short");
  a_hwrst_mode: assert property ($rose(fl_reset_n) |-> mode == fbc_pkg::FBC_MODE_ARRAY)  // [R22]
    else $error("mode not array after pin reset");
  a_auto_mode: assert property (start && wcmd == fbc_pkg::FBC_CMD_AUTO && fl_ready  // [R21]
    |-> ##[10:40] mode == fbc_pkg::FBC_MODE_AUTO)
    else $error("autoselect mode not reached");
  a_read_data: assert property (sw_rd && sw_addr == `FBC_RG_FDATA |=> sw_rdata == 32'($past(fdata)))
    else $error("read data not one cycle later");

  c_auto_seq: cover property (mode == fbc_pkg::FBC_MODE_ARRAY ##[1:1000] mode == fbc_pkg::FBC_MODE_AUTO);
  c_sec_exit: cover property (mode == fbc_pkg::FBC_MODE_SEC ##[1:1000] mode == fbc_pkg::FBC_MODE_ARRAY);
  c_refused:  cover property ($rose(refused));
  c_hwrst:    cover property ($rose(fl_reset_n));
endmodule : fbc_host
`default_nettype wire

// file: verification/fbc_flash_model.sv
// Purpose: Behavioural word-mode flash that answers the host controller's pins.
// Assumes: Word mode only; reads are served at once, well inside the capture time.
// Notes: A released data bus shows the inverse of the last value read, never a held copy.
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model #(
  parameter logic [15:0] MFR_CODE   = 16'h00c3,
  parameter logic [15:0] DEV_CODE   = 16'h2233,
  parameter logic [7:0]  BANK2_SECT = 8'h1f,
  parameter logic [7:0]  BOOT_FLAG  = 8'h02
) (
  // Pins from the controller.
  input  wire logic [19:0] fl_addr,
  input  wire logic [15:0] fl_dq_out,
  input  wire logic        fl_dq_oe_n,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_reset_n,
  // Test control.
  input  wire logic        busy,
  // Pins to the controller.
  output logic      [15:0] fl_dq_in,
  output logic             fl_ready
);
  // The two identity codes above are arbitrary values.
  logic [19:0] lat_a  = 20'h0;
  logic        wr_act = 1'b0;
  logic [1:0]  mode   = 2'h0;
  logic        sec    = 1'b0;
  logic        susp   = 1'b0;
  logic [7:0]  susp_s = 8'h0;
  logic [1:0]  cyc    = 2'h0;
  logic [15:0] rd_v;
  logic [15:0] last_v = 16'h0;
  logic [7:0]  d;
  always @(negedge fl_we_n or negedge fl_ce_n) if (!fl_we_n && !fl_ce_n) begin
    wr_act = 1'b1;
    lat_a  = fl_addr;
  end
  always @(posedge fl_we_n or posedge fl_ce_n) if (wr_act) begin
    wr_act = 1'b0;
    d = fl_dq_out[7:0];
    if (d == 8'hf0) begin
      // The suspend flag is left alone, so a suspended bank returns to suspend-read.
      cyc  = 2'h0;
      mode = 2'h0;
    end else if (cyc == 0 && d == 8'hb0) begin
      // The sector named with the suspend command is taken as the one under erase.
      susp   = 1'b1;
      susp_s = lat_a[19:12];
    end else if (cyc == 0 && d == 8'h30) susp = 1'b0;
    else if (cyc == 0 && lat_a[11:0] == 12'h055 && d == 8'h98) mode = 2'h2;
    else if (cyc == 0 && lat_a[11:0] == 12'h555 && d == 8'haa) cyc = 2'h1;
    else if (cyc == 1 && lat_a[11:0] == 12'h2aa && d == 8'h55) cyc = 2'h2;
    else if (cyc == 2 && d == 8'h88) begin
      sec = 1'b1;
      cyc = 2'h0;
    end else if (cyc == 2 && d == 8'h90 && sec) cyc = 2'h3;
    else if (cyc == 2 && d == 8'h90 && lat_a[11:0] == 12'h555) begin
      mode = 2'h1;
      cyc  = 2'h0;
    end else if (cyc == 3 && d == 8'h00) begin
      sec = 1'b0;
      cyc = 2'h0;
    end else cyc = 2'h0;
  end
  always @(negedge fl_reset_n) begin
    mode = 2'h0;
    sec  = 1'b0;
    susp = 1'b0;
    cyc  = 2'h0;
  end
  always @* begin
    if (sec) rd_v = {4'ha, fl_addr[11:0]};
    else if (mode == 2) begin
      // Entries sit on the low byte lane, so a byte-wide host sees them at twice the address.
      case (fl_addr[7:0])
        8'h40: rd_v = 16'h0050;
        8'h41: rd_v = 16'h0052;
        8'h42: rd_v = 16'h0049;
        8'h43, 8'h44: rd_v = 16'h0031;
        8'h46: rd_v = 16'h0002;
        8'h47, 8'h48: rd_v = 16'h0001;
        8'h49: rd_v = 16'h0004;
        8'h4a: rd_v = {8'h0, BANK2_SECT};
        8'h4d: rd_v = 16'h0085;
        8'h4e: rd_v = 16'h0095;
        8'h4f: rd_v = {8'h0, BOOT_FLAG};
        default: rd_v = 16'h0000;
      endcase
    end else if (mode == 1) begin
      case (fl_addr[7:0])
        8'h00: rd_v = MFR_CODE;
        8'h01: rd_v = DEV_CODE;
        8'h02: rd_v = {15'h0, fl_addr[12]};
        default: rd_v = 16'h0000;
      endcase
    end else if (susp && fl_addr[19:12] == susp_s) rd_v = 16'h0000;
    else rd_v = ~fl_addr[15:0];
  end
  always @(posedge fl_oe_n) last_v = rd_v;
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n && fl_dq_oe_n) ? rd_v : ~last_v;
  assign fl_ready = !busy;
endmodule : fbc_flash_model
`default_nettype wire

// file: verification/tb.sv
// Purpose: Self-checking bench for the flash command controller.
// Assumes: Commands are issued one at a time and busy is polled.
// Notes: Array reads in the model return the inverted address.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  sw_addr = 3'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic        fl_busy = 1'b0;
  logic [31:0] sw_rdata;
  logic [19:0] fl_addr;
  logic [15:0] fl_dq_in, fl_dq_out;
  logic        fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n, fl_ready;
  logic [31:0] v;
  int          failures = 0;
  int          compares = 0;
  logic [15:0] qexp [16] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0031, 16'h0000,
    16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h001f, 16'h0000, 16'h0000, 16'h0085,
    16'h0095, 16'h0002};
  fbc_host fbc_host_inst (.clk(clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .fl_addr(fl_addr),
    .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n), .fl_ready(fl_ready));
  fbc_flash_model fbc_flash_model_inst (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
    .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_reset_n(fl_reset_n), .busy(fl_busy), .fl_dq_in(fl_dq_in), .fl_ready(fl_ready));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [31:0] q);
    @(posedge clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    q = sw_rdata;
  endtask : rd
  task automatic cmd(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d);
    wr(3'h1, {12'h0, a});
    wr(3'h2, {16'h0, d});
    wr(3'h0, {28'h0, c});
    for (int i = 0; i < 100; i++) begin
      rd(3'h3, v);
      if (v[0] === 1'b0) break;
    end
    if (v[0] !== 1'b0) begin
      failures++;
      $display("mismatch at %0t: busy never cleared", $time);
    end
  endtask : cmd
  task automatic fread(input logic [19:0] a, input logic [15:0] exp);
    cmd(fbc_pkg::FBC_CMD_READ, a, 16'h0);
    rd(3'h4, v);
    chk(v, {16'h0, exp});
  endtask : fread
  task automatic mode_chk(input logic [1:0] m);
    rd(3'h3, v);
    chk({30'h0, v[3:2]}, {30'h0, m});
  endtask : mode_chk
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    mode_chk(2'h0);
    fread(20'h00123, ~16'h0123);
    rd(3'h5, v);
    chk(v, 32'h0);
    rd(3'h7, v);
    chk(v, 32'h0);
    cmd(fbc_pkg::FBC_CMD_QUERY, 20'h0, 16'h0);
    mode_chk(2'h2);
    for (int i = 0; i < 16; i++) fread(20'h40 + i, qexp[i]);
    cmd(fbc_pkg::FBC_CMD_RESET, 20'hfffff, 16'h0);
    mode_chk(2'h0);
    fread(20'h00456, ~16'h0456);
    cmd(fbc_pkg::FBC_CMD_AUTO, 20'h1f000, 16'h0);
    mode_chk(2'h1);
    fread(20'h1f000, 16'h00c3);
    fread(20'h1f001, 16'h2233);
    fread(20'h1f002, 16'h0001);
    fread(20'h0e002, 16'h0000);
    fread(20'h1f000, 16'h00c3);
    cmd(fbc_pkg::FBC_CMD_RESET, 20'h0, 16'h0);
    mode_chk(2'h0);
    fread(20'h1f000, ~16'hf000);
    fl_busy <= 1'b1;
    cmd(fbc_pkg::FBC_CMD_AUTO, 20'h1f000, 16'h0);
    chk({30'h0, v[3:2]}, 32'h0);
    chk({31'h0, v[1]}, 32'h1);
    chk({31'h0, v[4]}, 32'h0);
    fl_busy <= 1'b0;
    cmd(4'h8, 20'h0, 16'h0);
    chk({31'h0, v[1]}, 32'h1);
    cmd(fbc_pkg::FBC_CMD_WRITE, 20'h00555, 16'h00aa);
    cmd(fbc_pkg::FBC_CMD_WRITE, 20'h002aa, 16'h0055);
    cmd(fbc_pkg::FBC_CMD_WRITE, 20'h00000, 16'h00f0);
    cmd(fbc_pkg::FBC_CMD_WRITE, 20'h00555, 16'h0090);
    fread(20'h00000, 16'hffff);
    cmd(fbc_pkg::FBC_CMD_WRITE, 20'h1f000, 16'h00b0);
    fread(20'h1f123, 16'h0000);
    fread(20'h00123, ~16'h0123);
    cmd(fbc_pkg::FBC_CMD_WRITE, 20'h00555, 16'h00aa);
    cmd(fbc_pkg::FBC_CMD_WRITE, 20'h002aa, 16'h0055);
    cmd(fbc_pkg::FBC_CMD_WRITE, 20'h00000, 16'h00f0);
    fread(20'h1f123, 16'h0000);
    fread(20'h00123, ~16'h0123);
    cmd(fbc_pkg::FBC_CMD_WRITE, 20'h1f000, 16'h0030);
    fread(20'h1f123, ~16'hf123);
    cmd(fbc_pkg::FBC_CMD_SECIN, 20'h0, 16'h0);
    mode_chk(2'h3);
    fread(20'h00321, 16'ha321);
    cmd(fbc_pkg::FBC_CMD_SECOUT, 20'h0, 16'h0);
    mode_chk(2'h0);
    fread(20'h00321, ~16'h0321);
    cmd(fbc_pkg::FBC_CMD_QUERY, 20'h0, 16'h0);
    cmd(fbc_pkg::FBC_CMD_HWRST, 20'h0, 16'h0);
    mode_chk(2'h0);
    fread(20'h00041, ~16'h0041);
    stop_test();
  end
endmodule : tb
`default_nettype wire
